// ### phase_step_pkg.sv
/*
  phase_step_pkg: constants and carrier types for the phase step aligner.
  Assumes a single 100 MHz core clock; no software-visible registers.
*/
`default_nettype none
package phase_step_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_MAX_MHZ = 240;

  // ---------------------------------------------------------------
  // phase accumulator geometry
  // ---------------------------------------------------------------
  // finest grid: 3072 steps per output period
  localparam int PHASE_W = 12;
  localparam logic [PHASE_W-1:0] PHASE_FULL_M1 = 12'hBFF;   // 3071
  localparam logic [PHASE_W-1:0] PHASE_RESET   = 12'h000;
  localparam logic [PHASE_W-1:0] STEP_COARSE   = 12'h004;   // 1/768
  localparam logic [PHASE_W-1:0] STEP_MEDIUM   = 12'h002;   // 1/1536
  localparam logic [PHASE_W-1:0] STEP_FINE     = 12'h001;   // 1/3072

  // ---------------------------------------------------------------
  // skip pattern within each group of strobe edges
  // ---------------------------------------------------------------
  localparam int EDGE_CNT_W = 5;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RESET = 5'h00;
  localparam logic [EDGE_CNT_W-1:0] SKIP_EDGE_A    = 5'h1F;  // always skipped
  localparam logic [EDGE_CNT_W-1:0] SKIP_EDGE_B    = 5'h0F;  // skipped when enabled

  // ---------------------------------------------------------------
  // post-divider select codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    POST_OFF    = 2'b00,
    POST_FINE   = 2'b01,
    POST_MEDIUM = 2'b10,
    POST_COARSE = 2'b11
  } post_sel_type;

  typedef struct packed {
    logic step_strobe;
    logic direction_select;
  } step_req_type;

  typedef struct packed {
    logic                applied;
    logic                skipped;
    logic                advanced;
    logic [PHASE_W-1:0]  phase;
  } phase_stat_type;

endpackage
`default_nettype wire

// ### phase_wrap_adder.sv
/*
  phase_wrap_adder: modulo-period add or subtract of one phase step.
  Assumes inputs already lie within one output period.
*/
`timescale 1ns/10ps
`default_nettype none
module phase_wrap_adder (
  // operands
  input  wire logic [phase_step_pkg::PHASE_W-1:0] phase,
  input  wire logic [phase_step_pkg::PHASE_W-1:0] step,
  input  wire logic                               advance,
  // result
  output logic      [phase_step_pkg::PHASE_W-1:0] next_phase
);
  localparam logic [phase_step_pkg::PHASE_W:0] PERIOD =
    {1'b0, phase_step_pkg::PHASE_FULL_M1} + 13'h0001;

  logic [phase_step_pkg::PHASE_W:0] sum_up;
  logic [phase_step_pkg::PHASE_W:0] sum_dn;

  // advance lowers the delay offset, delay raises it
  assign sum_dn = {1'b0, phase} + {1'b0, step};
  assign sum_up = {1'b0, phase} + PERIOD - {1'b0, step};

  assign next_phase = advance
    ? ((sum_up >= PERIOD) ? 12'(sum_up - PERIOD) : sum_up[phase_step_pkg::PHASE_W-1:0])
    : ((sum_dn >= PERIOD) ? 12'(sum_dn - PERIOD) : sum_dn[phase_step_pkg::PHASE_W-1:0]);
endmodule // phase_wrap_adder
`default_nettype wire

// ### phase_step_aligner.sv
/*
  phase_step_aligner: keeps the delay offset of the multiplied output clock
  pair and moves it one step of the post_sel size per strobe rising edge that is not skipped.
  Assumes strobe and direction are synchronous to core_clk; the analogue
  phase interpolator consumes stat.phase.
// How it works
// RQ1: a strobe rising edge with direction high moves the output earlier by one step.
// RQ2: a strobe rising edge with direction low moves the output later by one step.
// RQ3: the step is 1/768, 1/1536 or 1/3072 of the period for select 11, 10, 01.
// RQ4: in each group of 32 strobe edges one or two edges leave the phase unchanged.
// RQ5: the driving party keeps the strobe at or below 240 MHz so each edge is distinct.
// RQ6: the phase offset wraps modulo one output period and never saturates.
*/
`timescale 1ns/10ps
`default_nettype none
module phase_step_aligner (
  // clock and reset
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_n,
  // step request pins
  input  wire phase_step_pkg::step_req_type         req,
  // configuration
  input  wire phase_step_pkg::post_sel_type         post_sel,
  input  wire logic                                 double_skip,
  // status toward the phase interpolator
  output var phase_step_pkg::phase_stat_type        stat
);

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  logic                                   strobe_prev;
  logic [phase_step_pkg::EDGE_CNT_W-1:0]  edge_cnt;
  logic [phase_step_pkg::PHASE_W-1:0]     phase;
  logic [phase_step_pkg::PHASE_W-1:0]     step;
  logic [phase_step_pkg::PHASE_W-1:0]     next_phase;
  logic                                   strobe_rise;
  logic                                   skip_now;
  logic                                   apply_now;

  // strobe at up to 240 MHz exceeds what a 100 MHz sampler resolves;
  // only edges seen at core_clk are counted
  assign strobe_rise = req.step_strobe & ~strobe_prev;  // RQ5

  // ---------------------------------------------------------------
  // step size and skip decode
  // ---------------------------------------------------------------
  assign step = (post_sel == phase_step_pkg::POST_COARSE) ? phase_step_pkg::STEP_COARSE :  // RQ3
                (post_sel == phase_step_pkg::POST_MEDIUM) ? phase_step_pkg::STEP_MEDIUM :
                (post_sel == phase_step_pkg::POST_FINE)   ? phase_step_pkg::STEP_FINE   :
                12'h000;

  // one fixed skip per group, a second one when double_skip is set
  assign skip_now  = strobe_rise &&
                     ((edge_cnt == phase_step_pkg::SKIP_EDGE_A) ||
                      (double_skip && edge_cnt == phase_step_pkg::SKIP_EDGE_B));  // RQ4
  assign apply_now = strobe_rise && !skip_now;

  phase_wrap_adder u_adder (
    .phase      (phase),
    .step       (step),
    .advance    (req.direction_select),
    .next_phase (next_phase)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= req.step_strobe;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= phase_step_pkg::EDGE_CNT_RESET;
    end else if (strobe_rise) begin
      edge_cnt <= edge_cnt + 5'h01;  // RQ4
    end
  end

  // advance/delay with wrap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= phase_step_pkg::PHASE_RESET;
    end else if (apply_now) begin
      phase <= next_phase;  // RQ1 RQ2 RQ6
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= '0;
    end else begin
      stat.applied  <= apply_now;
      stat.skipped  <= skip_now;
      stat.advanced <= apply_now & req.direction_select;
      stat.phase    <= apply_now ? next_phase : phase;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  localparam logic [12:0] PERIOD13 = {1'b0, phase_step_pkg::PHASE_FULL_M1} + 13'h0001;

  function automatic logic [12:0] fwd(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    fwd = (s >= PERIOD13) ? s - PERIOD13 : s;
  endfunction

  sequence rise_hi;
    strobe_rise && req.direction_select && !skip_now && post_sel != phase_step_pkg::POST_OFF;
  endsequence

  sequence rise_lo;
    strobe_rise && !req.direction_select && !skip_now && post_sel != phase_step_pkg::POST_OFF;
  endsequence

  chk_advance_one_step: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ1
    rise_hi |=> fwd(phase, $past(step)) == {1'b0, $past(phase)})
    else $error("advance did not move phase by one step");

  chk_delay_one_step: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ2
    rise_lo |=> {1'b0, phase} == fwd($past(phase), $past(step)))
    else $error("delay did not move phase by one step");

  chk_step_coarse: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ3
    post_sel == phase_step_pkg::POST_COARSE |-> step == 12'h004)
    else $error("coarse step size wrong");

  chk_step_finer: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ3
    (post_sel == phase_step_pkg::POST_MEDIUM |-> step == 12'h002) and
    (post_sel == phase_step_pkg::POST_FINE |-> step == 12'h001))
    else $error("medium or fine step size wrong");

  chk_skip_hold: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ4
    skip_now |=> $stable(phase) && stat.skipped && !stat.applied)
    else $error("skipped edge changed phase");

  chk_skip_slot: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ4
    strobe_rise && edge_cnt == 5'h1F |-> skip_now)
    else $error("32nd edge was not skipped");

  chk_no_strobe_hold: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ1
    !strobe_rise |=> $stable(phase))
    else $error("phase moved without strobe edge");

  chk_phase_wraps: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ6
    phase <= phase_step_pkg::PHASE_FULL_M1)
    else $error("phase left one period");

  chk_edge_count: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ4
    strobe_rise |=> edge_cnt == $past(edge_cnt) + 5'h01)
    else $error("edge counter did not advance");

  // ---------------------------------------------------------------
  // skip bookkeeping for the group checks
  // ---------------------------------------------------------------
  // skips seen so far in the current group of 32 rises; cleared at the
  // closing edge so a mid-group change of double_skip still counts right
  logic [1:0] group_skips;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_skips <= 2'h0;
    end else if (strobe_rise && edge_cnt == phase_step_pkg::SKIP_EDGE_A) begin
      group_skips <= 2'h0;
    end else if (skip_now) begin
      group_skips <= group_skips + 2'h1;
    end
  end

  sequence rise_seen;
    strobe_rise;
  endsequence

  sequence group_close;
    strobe_rise && edge_cnt == phase_step_pkg::SKIP_EDGE_A;
  endsequence

  sequence spare_slot;
    strobe_rise && double_skip && edge_cnt == phase_step_pkg::SKIP_EDGE_B;
  endsequence

  // ---------------------------------------------------------------
  // group, pulse and output checks
  // ---------------------------------------------------------------
  chk_group_skips: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ4
    group_close |-> group_skips <= 2'h1)
    else $error("group of 32 edges skipped more than two");

  chk_spare_skip: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ4
    spare_slot |-> skip_now)
    else $error("second skip slot was applied");

  chk_rise_once: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ1
    rise_seen |=> !strobe_rise)
    else $error("held strobe counted twice");

  chk_one_outcome: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ4
    rise_seen |=> stat.applied != stat.skipped)
    else $error("strobe edge neither applied nor skipped");

  chk_quiet_pulses: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ1
    !strobe_rise |=> !stat.applied && !stat.skipped && !stat.advanced)
    else $error("status pulse without strobe edge");

  chk_advanced_flag: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ1
    stat.advanced |-> stat.applied)
    else $error("advance flagged on an unapplied edge");

  chk_advance_dir: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ2
    apply_now |=> stat.advanced == $past(req.direction_select))
    else $error("advance flag does not follow direction");

  chk_stat_phase: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ6
    stat.phase == phase)
    else $error("reported phase differs from held phase");

  chk_step_off: assert property (@(posedge core_clk) disable iff (!rst_n)  // RQ3
    post_sel == phase_step_pkg::POST_OFF |-> step == 12'h000)
    else $error("step not zero with divider off");

endmodule // phase_step_aligner
`default_nettype wire

// ### step_source.sv
/*
  step_source: far-side model that drives the step strobe and direction pins.
  Assumes it shares core_clk with the aligner and is steered by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module step_source (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // steering from the bench
  input  wire logic                    fire,
  input  wire logic                    dir,
  input  wire logic                    hold,
  // pins toward the aligner
  output phase_step_pkg::step_req_type req
);
  // strobe always drops for a cycle before the next rise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
    end else if (!req.step_strobe && fire) begin
      req.step_strobe      <= 1'b1;
      req.direction_select <= dir;
    end else if (req.step_strobe && !hold) begin
      req.step_strobe      <= 1'b0;
      // stale direction must not look valid after release
      req.direction_select <= ~req.direction_select;
    end
  end
endmodule // step_source
`default_nettype wire

// ### test_phase_step_aligner.sv
/*
  test_phase_step_aligner: self-checking bench with a reference phase model.
  Assumes stat answers one cycle after a sampled strobe rise.
*/
`timescale 1ns/10ps
`default_nettype none
module test_phase_step_aligner;
  logic                           core_clk;
  logic                           rst_n;
  logic                           double_skip;
  logic                           fire;
  logic                           dir;
  logic                           hold;
  logic                           prev_strobe;
  logic [4:0]                     edge_cnt;
  phase_step_pkg::post_sel_type   post_sel;
  phase_step_pkg::step_req_type   req;
  phase_step_pkg::phase_stat_type stat;
  phase_step_pkg::phase_stat_type exp_stat;
  int                             n_fail;
  int                             check_count;

  phase_step_aligner phase_step_aligner_inst (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .post_sel(post_sel), .double_skip(double_skip), .stat(stat));
  step_source step_source_inst (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .dir(dir),
    .hold(hold), .req(req));

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [11:0] moved(input logic [11:0] ph, input logic [1:0] sel,
                                        input logic adv);
    int step;
    int p;
    step = (sel == 2'h3) ? 4 : (sel == 2'h2) ? 2 : (sel == 2'h1) ? 1 : 0;
    p = adv ? int'(ph) - step : int'(ph) + step;
    if (p < 0) p += 3072;
    if (p >= 3072) p -= 3072;
    return p[11:0];
  endfunction

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_stat = '0;
      prev_strobe = 1'b0;
      edge_cnt = 5'h00;
    end else begin
      exp_stat.applied = 1'b0;
      exp_stat.skipped = 1'b0;
      exp_stat.advanced = 1'b0;
      if (req.step_strobe && !prev_strobe) begin
        if (edge_cnt == phase_step_pkg::SKIP_EDGE_A ||
            (double_skip && edge_cnt == phase_step_pkg::SKIP_EDGE_B)) begin
          exp_stat.skipped = 1'b1;
        end else begin
          exp_stat.applied = 1'b1;
          exp_stat.advanced = req.direction_select;
          exp_stat.phase = moved(exp_stat.phase, post_sel, req.direction_select);
        end
        edge_cnt = edge_cnt + 5'h01;
      end
      prev_strobe = req.step_strobe;
    end
  end

  task automatic check_stat(input phase_step_pkg::phase_stat_type e);
    check_count++;
    if (stat !== e) begin
      n_fail++;
      $display("MISMATCH %0t stat %h expected %h", $time, stat, e);
    end
  endtask

  // the clock's first fall at time zero races the reset of both sides
  always @(negedge core_clk) if ($time > 0) check_stat(exp_stat);

  task automatic give_verdict;
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    n_fail++;
    give_verdict;
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    post_sel = phase_step_pkg::POST_COARSE;
    {double_skip, fire, dir, hold} = 4'h0;
    void'($urandom(20));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    // advance from zero must wrap below the period end
    dir <= 1'b1;
    fire <= 1'b1;
    repeat (8) @(posedge core_clk);
    // a strobe held high counts once
    hold <= 1'b1;
    repeat (6) @(posedge core_clk);
    hold <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      post_sel <= phase_step_pkg::post_sel_type'($urandom_range(3, 0));
      double_skip <= (i >= 1500);
      fire <= ($urandom_range(3, 0) != 0);
      dir <= (i < 300) ? 1'b0 : 1'($urandom_range(1, 0));
      hold <= ($urandom_range(7, 0) == 0);
      if (i == 2000) rst_n <= 1'b0;
      if (i == 2003) rst_n <= 1'b1;
    end
    repeat (4) @(posedge core_clk);
    give_verdict;
  end
endmodule // test_phase_step_aligner
`default_nettype wire
